// ==== sfpp_defs.svh ====
`ifndef SFPP_DEFS_SVH
`define SFPP_DEFS_SVH

// Command opcodes.
`define SFPP_OP_WR_ENABLE  8'h06
`define SFPP_OP_WR_DISABLE 8'h04
`define SFPP_OP_STATUS_WR  8'h01
`define SFPP_OP_READ       8'h03
`define SFPP_OP_FAST_READ  8'h0B
`define SFPP_OP_DUAL_OUT   8'h3B
`define SFPP_OP_DUAL_IO    8'hBB
`define SFPP_OP_QUAD_OUT   8'h6B
`define SFPP_OP_QUAD_IO    8'hEB
`define SFPP_OP_PAGE_PROG  8'h02
`define SFPP_OP_SECT_ERASE 8'h20
`define SFPP_OP_BLK32_ERS  8'h52
`define SFPP_OP_BLK64_ERS  8'hD8
`define SFPP_OP_CHIP_ERASE 8'hC7
`define SFPP_OP_DEEP_PD    8'hB9
`define SFPP_OP_RELEASE_PD 8'hAB
`define SFPP_OP_RST_ENABLE 8'h66
`define SFPP_OP_RST_DEVICE 8'h99

// Status register one field positions.
`define SFPP_SR_PROT0_POS  7
`define SFPP_SR_BP_MSB     6
`define SFPP_SR_BP_LSB     2

// Geometry of the larger density.
`define SFPP_DEV_BYTES     24'h080000
`define SFPP_SECTOR_BYTES  24'h001000
`define SFPP_BLOCK_BYTES   24'h010000
`define SFPP_ADDR_MSB      18

// Serial frame counts.
`define SFPP_OPCODE_BITS   6'h08
`define SFPP_ADDR_BITS     6'h18

`endif

// ==== sfpp_pkg.sv ====
package sfpp_pkg;

  typedef enum logic [1:0] {
    SFPP_W1,
    SFPP_W2,
    SFPP_W4
  } sfpp_width_t;

  // Status bits that steer protection and quad mode.
  typedef struct packed {
    logic       prot1;
    logic       prot0;
    logic       comp;
    logic       quad_en;
    logic [4:0] bp;
  } sfpp_status_t;

  // A request issued to the array after the frame ends.
  typedef struct packed {
    logic        prog;
    logic        erase;
    logic        wr_status;
    logic [23:0] addr;
    logic [7:0]  sr_data;
  } sfpp_req_t;

  // The four data lanes as seen at the pins.
  typedef struct packed {
    logic [3:0] in;
    logic [3:0] out;
    logic [3:0] oe;
  } sfpp_lanes_t;

endpackage

// ==== sfpp_top.sv ====
`timescale 1ns/100ps
`include "sfpp_defs.svh"

module sfpp_top (
  input  wire logic                 i_core_clk,   // Core clock, 125 MHz.
  input  wire logic                 i_rst,        // Asynchronous reset, active high.
  input  wire logic                 i_sclk,       // Serial clock from host.
  input  wire logic                 i_cs_n,       // Chip select, active low.
  input  wire logic [3:0]           i_io,         // Lane inputs 0..3.
  output logic      [3:0]           o_io,         // Lane outputs 0..3.
  output logic      [3:0]           o_io_oe,      // Lane output enables.
  input  wire logic                 i_array_busy, // Array operation in progress.
  input  wire logic [7:0]           i_rd_data,    // Array read byte.
  output sfpp_pkg::sfpp_req_t       o_req,        // Array request.
  output logic                      o_req_valid,  // Request pulse, core clock.
  output sfpp_pkg::sfpp_status_t    o_status,     // Current status bits.
  output logic                      o_wel,        // Write enable latch.
  output logic                      o_deep_pd,    // Deep power-down state.
  output logic                      o_paused,     // Pause active.
  output logic                      o_refused     // Last request refused, pulse.
);
  import sfpp_pkg::*;

  // Link domain: serial clock. Pause pin is lane 3, protect pin lane 2.
  logic              pause_pin;
  logic              wp_pin;
  sfpp_status_t      st_r;
  logic              quad_mode;
  assign pause_pin = i_io[3];
  assign wp_pin    = i_io[2];
  assign quad_mode = st_r.quad_en;

  // Pause state lives in the serial domain but may only move at clock-low
  // moments; it is evaluated on falling clock edges and on select rise.
  logic pause_r;
  logic pause_ok;
  assign pause_ok = !quad_mode;
  always_ff @(negedge i_sclk or posedge i_cs_n) begin
    if (i_cs_n) begin
      pause_r <= 1'b0;
    end else begin
      pause_r <= pause_ok && !pause_pin;
    end
  end

  // Frame state: bit counter, shift register, opcode, address.
  logic [5:0]        bitcnt_r;
  logic [7:0]        shift_r;
  logic [7:0]        opcode_r;
  logic [23:0]       addr_r;
  logic [7:0]        srdata_r;
  logic              have_op_r;
  logic              have_addr_r;
  logic              have_sr_r;
  sfpp_width_t       width_r;
  logic [3:0]        in_bits;
  logic [2:0]        step;
  logic              sclk_active;

  assign sclk_active = !pause_r;

  // Width in bits per clock for the current phase.
  function automatic logic [2:0] lanes_of(input sfpp_width_t w);
    unique case (w)
      SFPP_W1: lanes_of = 3'h1;
      SFPP_W2: lanes_of = 3'h2;
      SFPP_W4: lanes_of = 3'h4;
    endcase
  endfunction

  function automatic logic is_quad_op(input logic [7:0] op);
    is_quad_op = (op == `SFPP_OP_QUAD_OUT) || (op == `SFPP_OP_QUAD_IO);
  endfunction

  function automatic logic is_dual_op(input logic [7:0] op);
    is_dual_op = (op == `SFPP_OP_DUAL_OUT) || (op == `SFPP_OP_DUAL_IO);
  endfunction

  // Address phase runs wide only for the I/O variants.
  sfpp_width_t addr_width;
  assign addr_width = (opcode_r == `SFPP_OP_DUAL_IO) ? SFPP_W2 :
                      (opcode_r == `SFPP_OP_QUAD_IO && quad_mode) ? SFPP_W4 : SFPP_W1;
  assign step    = lanes_of(have_op_r ? addr_width : SFPP_W1);
  assign in_bits = i_io;

  // Deep power-down and reset-enable state are held in the serial domain.
  logic pd_r;
  logic rst_en_r;
  logic wel_r;
  logic [7:0] next_byte;
  assign next_byte = (step == 3'h4) ? {shift_r[3:0], in_bits} :
                     (step == 3'h2) ? {shift_r[5:0], in_bits[1:0]} :
                                      {shift_r[6:0], in_bits[0]};

  // Command decode of a completed opcode.
  logic op_done;
  logic op_allowed;
  assign op_done    = !have_op_r && (bitcnt_r == `SFPP_OPCODE_BITS - 6'h1);
  assign op_allowed = !pd_r || next_byte == `SFPP_OP_RELEASE_PD ||
                      next_byte == `SFPP_OP_RST_ENABLE ||
                      (rst_en_r && next_byte == `SFPP_OP_RST_DEVICE);

  // Sampling of input bits on rising edge; select high clears the frame.
  always_ff @(posedge i_sclk or posedge i_cs_n) begin
    if (i_cs_n) begin
      bitcnt_r    <= 6'h00;
      shift_r     <= 8'h00;
      have_op_r   <= 1'b0;
      have_addr_r <= 1'b0;
      have_sr_r   <= 1'b0;
      opcode_r    <= 8'h00;
      addr_r      <= 24'h000000;
      srdata_r    <= 8'h00;
    end else if (sclk_active) begin
      shift_r <= next_byte;
      if (!have_op_r) begin
        bitcnt_r <= bitcnt_r + 6'h1;
        if (op_done) begin
          opcode_r  <= op_allowed ? next_byte : 8'h00;
          have_op_r <= 1'b1;
          bitcnt_r  <= 6'h00;
        end
      end else if (!have_addr_r) begin
        bitcnt_r <= bitcnt_r + {3'h0, step};
        addr_r   <= (step == 3'h4) ? {addr_r[19:0], in_bits} :
                    (step == 3'h2) ? {addr_r[21:0], in_bits[1:0]} :
                                     {addr_r[22:0], in_bits[0]};
        if (opcode_r == `SFPP_OP_STATUS_WR && bitcnt_r == 6'h07) begin
          srdata_r  <= next_byte;
          have_sr_r <= 1'b1;
        end
        if (bitcnt_r + {3'h0, step} >= `SFPP_ADDR_BITS) begin
          have_addr_r <= 1'b1;
        end
      end
    end
  end

  // Commands that act at select rise, evaluated in the serial domain.
  logic        is_prog;
  logic        is_erase;
  logic        is_chip;
  logic        write_cmd;
  logic [23:0] span;
  logic        in_prot;
  logic [23:0] prot_lo;
  logic [23:0] prot_hi;
  logic        prot_all;
  logic        prot_none;

  assign is_prog   = opcode_r == `SFPP_OP_PAGE_PROG;
  assign is_chip   = opcode_r == `SFPP_OP_CHIP_ERASE;
  assign is_erase  = opcode_r == `SFPP_OP_SECT_ERASE || opcode_r == `SFPP_OP_BLK32_ERS ||
                     opcode_r == `SFPP_OP_BLK64_ERS || is_chip;
  assign write_cmd = is_prog || is_erase || (opcode_r == `SFPP_OP_STATUS_WR && have_sr_r);

  // Protected window for the larger density, before complement.
  logic [23:0] size_sel;
  logic        top_half;
  assign top_half = !st_r.bp[3];
  assign size_sel = st_r.bp[4] ?
                    ((st_r.bp[2:0] == 3'h1) ? `SFPP_SECTOR_BYTES :
                     (st_r.bp[2:0] == 3'h2) ? 24'h002000 :
                     (st_r.bp[2:0] == 3'h3) ? 24'h004000 : 24'h008000) :
                    ((st_r.bp[1:0] == 2'h1) ? `SFPP_BLOCK_BYTES :
                     (st_r.bp[1:0] == 2'h2) ? 24'h020000 : 24'h040000);
  assign prot_none = (st_r.bp[2:0] == 3'h0);
  assign prot_all  = st_r.bp[4] ? (st_r.bp[2:0] == 3'h7) : st_r.bp[2];
  assign prot_lo   = top_half ? (`SFPP_DEV_BYTES - size_sel) : 24'h000000;
  assign prot_hi   = top_half ? `SFPP_DEV_BYTES : size_sel;

  // Page/sector/block granularity of the target; chip erase spans everything.
  logic [23:0] tgt_lo;
  logic [23:0] tgt_hi;
  logic        hit_base;
  logic        hit;
  assign span   = (opcode_r == `SFPP_OP_SECT_ERASE) ? `SFPP_SECTOR_BYTES :
                  (opcode_r == `SFPP_OP_BLK32_ERS) ? 24'h008000 :
                  (opcode_r == `SFPP_OP_BLK64_ERS) ? `SFPP_BLOCK_BYTES : 24'h000100;
  assign tgt_lo = is_chip ? 24'h000000 : (addr_r & ~(span - 24'h000001));
  assign tgt_hi = is_chip ? `SFPP_DEV_BYTES : (tgt_lo + span);
  // A target counts as protected when any byte of it overlaps the window.
  assign hit_base = prot_all || (!prot_none && tgt_lo < prot_hi && tgt_hi > prot_lo);
  // Complemented ranges: any target not fully inside the unprotected window; every target when the whole array is selected.
  logic        free_base_cover;
  assign free_base_cover = prot_all ? 1'b0 : prot_none ? 1'b0 :
                           (tgt_lo >= prot_lo && tgt_hi <= prot_hi);
  assign hit    = st_r.comp ? !free_base_cover : hit_base;
  assign in_prot = (is_prog || is_erase) && hit;

  // Status write honours the protect pin for protection bits.
  sfpp_status_t sr_new;
  always_comb begin
    sr_new = st_r;
    sr_new.quad_en = srdata_r[1];
    if (!(st_r.prot0 && !wp_pin)) begin
      sr_new.prot0 = srdata_r[`SFPP_SR_PROT0_POS];
      sr_new.bp   = srdata_r[`SFPP_SR_BP_MSB:`SFPP_SR_BP_LSB];
    end
  end

  logic        accept;
  logic        tog_r;
  sfpp_req_t   req_r;
  logic        refuse_r;
  // A busy array refuses the request rather than queueing it, so the host
  // must wait for completion before it sends the next write.
  assign accept = write_cmd && wel_r && !in_prot && !i_array_busy;

  // End-of-frame actions run on select rise.
  always_ff @(posedge i_cs_n or posedge i_rst) begin
    if (i_rst) begin
      wel_r    <= 1'b0;
      pd_r     <= 1'b0;
      rst_en_r <= 1'b0;
      st_r     <= '0;
      tog_r    <= 1'b0;
      req_r    <= '0;
      refuse_r <= 1'b0;
    end else if (have_op_r && !pause_r) begin
      rst_en_r <= opcode_r == `SFPP_OP_RST_ENABLE;
      refuse_r <= write_cmd && !accept;
      if (opcode_r == `SFPP_OP_WR_ENABLE) begin
        wel_r <= 1'b1;
      end else if (opcode_r == `SFPP_OP_WR_DISABLE || accept) begin
        wel_r <= 1'b0;
      end
      if (rst_en_r && opcode_r == `SFPP_OP_RST_DEVICE) begin
        wel_r <= 1'b0;
        pd_r  <= 1'b0;
      end
      if (opcode_r == `SFPP_OP_DEEP_PD) begin
        pd_r <= 1'b1;
      end else if (opcode_r == `SFPP_OP_RELEASE_PD) begin
        pd_r <= 1'b0;
      end
      if (accept) begin
        req_r.prog      <= is_prog;
        req_r.erase     <= is_erase;
        req_r.wr_status <= opcode_r == `SFPP_OP_STATUS_WR;
        req_r.addr      <= tgt_lo;
        req_r.sr_data   <= srdata_r;
        tog_r           <= ~tog_r;
        if (opcode_r == `SFPP_OP_STATUS_WR) begin
          st_r <= sr_new;
        end
      end
    end
  end

  // Output shifting on falling edge; lane width per read opcode.
  logic [3:0] out_r;
  logic [3:0] oe_r;
  logic       data_phase;
  logic       read_op;
  logic       quad_ok;
  sfpp_width_t out_w;
  assign read_op    = opcode_r == `SFPP_OP_READ || opcode_r == `SFPP_OP_FAST_READ ||
                      is_dual_op(opcode_r) || is_quad_op(opcode_r);
  assign quad_ok    = is_quad_op(opcode_r) && quad_mode;
  assign data_phase = have_addr_r && read_op && (quad_ok || !is_quad_op(opcode_r));
  assign out_w      = quad_ok ? SFPP_W4 :
                      is_dual_op(opcode_r) ? SFPP_W2 : SFPP_W1;

  logic [2:0] obit_r;
  always_ff @(negedge i_sclk or posedge i_cs_n) begin
    if (i_cs_n) begin
      obit_r <= 3'h7;
      out_r  <= 4'h0;
      oe_r   <= 4'h0;
    end else if (pause_ok && !pause_pin) begin
      oe_r <= 4'h0;
    end else if (data_phase) begin
      obit_r <= obit_r - lanes_of(out_w);
      unique case (out_w)
        SFPP_W4: begin
          out_r <= obit_r[2] ? i_rd_data[7:4] : i_rd_data[3:0];
          oe_r  <= 4'hF;
        end
        SFPP_W2: begin
          out_r <= {2'h0, i_rd_data[obit_r -: 2]};
          oe_r  <= 4'h3;
        end
        SFPP_W1: begin
          out_r <= {2'h0, i_rd_data[obit_r], 1'b0};
          oe_r  <= 4'h2;
        end
      endcase
    end
  end
  assign o_io    = out_r;
  assign o_io_oe = oe_r;

  // Crossing to the core clock: levels via two flops, requests via toggle.
  logic [2:0] tog_sync_r;
  logic [1:0] pd_sync_r;
  logic [1:0] ps_sync_r;
  logic [1:0] wel_sync_r;
  logic [1:0] rf_sync_r;
  logic       rf_last_r;
  logic       req_seen;
  // The request word and the status are copied only once the toggle has
  // been seen; by then both have been stable for several core cycles, so
  // the copy can never mix bits of two different updates.
  assign req_seen = tog_sync_r[2] ^ tog_sync_r[1];
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      tog_sync_r  <= 3'h0;
      pd_sync_r   <= 2'h0;
      ps_sync_r   <= 2'h0;
      wel_sync_r  <= 2'h0;
      rf_sync_r   <= 2'h0;
      rf_last_r   <= 1'b0;
      o_req_valid <= 1'b0;
      o_req       <= '0;
      o_status    <= '0;
      o_wel       <= 1'b0;
      o_deep_pd   <= 1'b0;
      o_paused    <= 1'b0;
      o_refused   <= 1'b0;
    end else begin
      tog_sync_r  <= {tog_sync_r[1:0], tog_r};
      pd_sync_r   <= {pd_sync_r[0], pd_r};
      ps_sync_r   <= {ps_sync_r[0], pause_r};
      wel_sync_r  <= {wel_sync_r[0], wel_r};
      rf_sync_r   <= {rf_sync_r[0], refuse_r};
      rf_last_r   <= rf_sync_r[1];
      o_req_valid <= req_seen;
      if (req_seen) begin
        o_req    <= req_r;
        o_status <= st_r;
      end
      o_wel       <= wel_sync_r[1];
      o_deep_pd   <= pd_sync_r[1];
      o_paused    <= ps_sync_r[1];
      o_refused   <= rf_sync_r[1] & ~rf_last_r;
    end
  end

endmodule

// ==== sfpp_chk.sv ====
`timescale 1ns/100ps
module sfpp_chk (
  input  wire logic                   i_core_clk,   // Core clock.
  input  wire logic                   i_rst,        // Reset, active high.
  input  wire logic                   i_array_busy, // Array busy.
  input  wire logic [3:0]             o_io_oe,      // Lane enables.
  input  wire sfpp_pkg::sfpp_req_t    o_req,        // Array request.
  input  wire logic                   o_req_valid,  // Request pulse.
  input  wire sfpp_pkg::sfpp_status_t o_status,     // Status bits.
  input  wire logic                   o_wel,        // Write enable latch.
  input  wire logic                   o_deep_pd,    // Power-down state.
  input  wire logic                   o_paused,     // Pause state.
  input  wire logic                   o_refused     // Refusal pulse.
);
  import sfpp_pkg::*;
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  sequence s_req_pulse;
    o_req_valid ##1 !o_req_valid;
  endsequence
  sequence s_ref_pulse;
    o_refused ##1 !o_refused;
  endsequence
  chk_req_single: assert property (o_req_valid |-> s_req_pulse)
    else $error("request pulse lasted more than one cycle");
  chk_ref_single: assert property (o_refused |-> s_ref_pulse)
    else $error("refusal pulse lasted more than one cycle");
  chk_req_not_refused: assert property (o_req_valid |-> !o_refused)
    else $error("request and refusal seen together");
  chk_pause_float: assert property (o_paused |-> o_io_oe == 4'h0)
    else $error("lane driven while paused");
  chk_pd_no_wel: assert property (o_deep_pd && !o_wel |=> !o_wel)
    else $error("latch set in power-down");
  chk_pd_no_req: assert property (o_deep_pd |-> !o_req_valid)
    else $error("request issued in power-down");
  chk_top_guard: assert property (o_req_valid && o_req.prog && o_status == 9'h001
    |-> o_req.addr < 24'h070000)
    else $error("program issued into protected top block");
  chk_busy_no_req: assert property (i_array_busy |-> !o_req_valid)
    else $error("request issued while array busy");
endmodule

bind sfpp_top sfpp_chk chk_u (
  .i_core_clk, .i_rst, .i_array_busy, .o_io_oe, .o_req, .o_req_valid,
  .o_status, .o_wel, .o_deep_pd, .o_paused, .o_refused
);

// ==== sfpp_host.sv ====
`timescale 1ns/100ps
module sfpp_host (
  output logic       o_sclk, // Serial clock, idles at idle_hi.
  output logic       o_cs_n, // Chip select.
  output logic [3:0] o_io    // Lanes driven by the host.
);
  logic idle_hi; // Clock idle level: 0 for mode zero, 1 for mode three.
  initial begin
    idle_hi = 1'b0;
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_io   = 4'hD;
  end
  // Sends n bits MSB first; pauses after the rising edge of bit p when p >= 0.
  // The clock idles at idle_hi and stands still outside the frame.
  task automatic frame(input logic [39:0] d, input int n, input int p);
    int i;
    o_sclk = idle_hi;
    #4 o_cs_n = 1'b0;
    #4;
    for (i = n - 1; i >= 0; i--) begin
      o_sclk = 1'b0;
      o_io[0] = d[i];
      #3 o_sclk = 1'b1;
      if (i == p) begin
        o_io[3] = 1'b0;
        #3 o_sclk = 1'b0;
        #200 o_io[0] = ~o_io[0];
        #3 o_sclk = 1'b1;
        o_io[3] = 1'b1;
      end
      #3;
    end
    if (!idle_hi) o_sclk = 1'b0;
    // The released data line shows the inverse of its last bit.
    o_io[0] = ~o_io[0];
    #3 o_cs_n = 1'b1;
  endtask
endmodule

// ==== sfpp_bench.sv ====
`timescale 1ns/100ps
`define SFPP_CHK(nm, ex, gt) begin num_checks++; if ((gt) !== (ex)) begin err_total++; \
  $display("Error %s expected %0h seen %0h", nm, ex, gt); end end
module sfpp_bench;
  import sfpp_pkg::*;
  logic         i_core_clk;
  logic         i_rst;
  logic         i_array_busy;
  wire          sclk;
  wire          cs_n;
  wire  [3:0]   h_io;
  wire  [3:0]   io_w;
  logic [3:0]   o_io;
  logic [3:0]   o_io_oe;
  sfpp_req_t    o_req;
  sfpp_req_t    req_q;
  sfpp_status_t o_status;
  logic         o_req_valid;
  logic         o_wel;
  logic         o_deep_pd;
  logic         o_paused;
  logic         o_refused;
  logic         seen_req;
  logic         seen_ref;
  logic         seen_p;
  logic [7:0]   rd_byte;
  logic [7:0]   rd_sh;
  int           err_total;
  int           num_checks;
  assign io_w = (o_io_oe & o_io) | (~o_io_oe & h_io);
  sfpp_host host_u (.o_sclk(sclk), .o_cs_n(cs_n), .o_io(h_io));
  sfpp_top dut_u (
    .i_core_clk(i_core_clk), .i_rst(i_rst), .i_sclk(sclk), .i_cs_n(cs_n), .i_io(io_w),
    .o_io(o_io), .o_io_oe(o_io_oe), .i_array_busy(i_array_busy), .i_rd_data(rd_byte),
    .o_req(o_req), .o_req_valid(o_req_valid), .o_status(o_status), .o_wel(o_wel),
    .o_deep_pd(o_deep_pd), .o_paused(o_paused), .o_refused(o_refused)
  );
  initial begin
    i_core_clk = 1'b0;
    forever #4 i_core_clk = ~i_core_clk;
  end
  always @(posedge i_core_clk) begin
    if (o_req_valid) begin
      seen_req <= 1'b1;
      req_q <= o_req;
    end
    if (o_refused) seen_ref <= 1'b1;
    if (o_paused) seen_p <= 1'b1;
  end
  always @(posedge sclk) begin
    if (!cs_n) rd_sh <= {rd_sh[6:0], io_w[1]};
  end
  task automatic cmd(input logic [39:0] d, input int n, input int p);
    seen_req = 1'b0;
    seen_ref = 1'b0;
    seen_p = 1'b0;
    host_u.frame(d, n, p);
    repeat (12) @(negedge i_core_clk);
  endtask
  task automatic t_latch;
    cmd(32'h06, 8, -1);
    `SFPP_CHK("wel after enable", 1'b1, o_wel)
    cmd(32'h04, 8, -1);
    `SFPP_CHK("wel after disable", 1'b0, o_wel)
    $display("test latch done");
  endtask
  task automatic t_read;
    cmd({8'h03, 24'h001000, 8'h00}, 40, -1);
    `SFPP_CHK("read byte", 8'hA5, rd_sh)
    `SFPP_CHK("lanes released", 4'h0, o_io_oe)
    $display("test read done");
  endtask
  task automatic t_mode3;
    host_u.idle_hi = 1'b1;
    cmd(40'h06, 8, -1);
    `SFPP_CHK("wel mode three", 1'b1, o_wel)
    cmd(40'h04, 8, -1);
    `SFPP_CHK("wel cleared mode three", 1'b0, o_wel)
    host_u.idle_hi = 1'b0;
    $display("test mode three done");
  endtask
  task automatic t_refuse;
    cmd(32'h0104, 16, -1);
    `SFPP_CHK("status write refused", 1'b1, seen_ref)
    `SFPP_CHK("protect bits kept", 5'h00, o_status.bp)
    $display("test refuse done");
  endtask
  task automatic t_protect;
    logic [7:0] ops [5];
    ops = '{8'h02, 8'h20, 8'h52, 8'hD8, 8'hC7};
    cmd(32'h06, 8, -1);
    cmd(32'h0104, 16, -1);
    `SFPP_CHK("protect bits", 5'h01, o_status.bp)
    `SFPP_CHK("wel after status write", 1'b0, o_wel)
    foreach (ops[k]) begin
      cmd(32'h06, 8, -1);
      cmd({ops[k], 24'h070000}, 32, -1);
      `SFPP_CHK("protected refused", 1'b1, seen_ref)
      `SFPP_CHK("protected no request", 1'b0, seen_req)
    end
    cmd(32'h06, 8, -1);
    cmd({8'h02, 24'h06F000}, 32, -1);
    `SFPP_CHK("open program issued", 1'b1, seen_req)
    `SFPP_CHK("program address", 24'h06F000, req_q.addr)
    `SFPP_CHK("program kind", 1'b1, req_q.prog)
    i_array_busy = 1'b1;
    repeat (20) @(negedge i_core_clk);
    i_array_busy = 1'b0;
    repeat (12) @(negedge i_core_clk);
    `SFPP_CHK("wel after program", 1'b0, o_wel)
    $display("test protect done");
  endtask
  task automatic t_pause;
    cmd(32'h06, 8, 3);
    `SFPP_CHK("pause entered", 1'b1, seen_p)
    `SFPP_CHK("enable across pause", 1'b1, o_wel)
    cmd(32'h66, 8, -1);
    cmd(32'h99, 8, -1);
    `SFPP_CHK("wel after soft reset", 1'b0, o_wel)
    $display("test pause done");
  endtask
  task automatic t_pd;
    cmd(32'hB9, 8, -1);
    `SFPP_CHK("power-down entered", 1'b1, o_deep_pd)
    cmd(32'h06, 8, -1);
    `SFPP_CHK("enable ignored", 1'b0, o_wel)
    cmd(32'hAB, 8, -1);
    `SFPP_CHK("power-down left", 1'b0, o_deep_pd)
    cmd(32'h06, 8, -1);
    `SFPP_CHK("enable after release", 1'b1, o_wel)
    $display("test power-down done");
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    #100000;
    err_total++;
    end_sim();
  end
  initial begin
    i_rst = 1'b1;
    i_array_busy = 1'b0;
    rd_byte = 8'hA5;
    seen_req = 1'b0;
    seen_ref = 1'b0;
    seen_p = 1'b0;
    err_total = 0;
    num_checks = 0;
    repeat (4) @(negedge i_core_clk);
    i_rst = 1'b0;
    repeat (3) @(negedge i_core_clk);
    t_latch();
    t_read();
    t_mode3();
    t_refuse();
    t_protect();
    t_pause();
    t_pd();
    end_sim();
  end
endmodule
